// >>> src/csl_pkg.sv
// constants and types shared by the counter supervision logic
package csl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam longint unsigned FLASH_CYCLE_MS = 1000;
  // half of the flash cycle, in core_clk cycles
  localparam longint unsigned FLASH_HALF_CYC = (FLASH_CYCLE_MS * 64'd1000000 / 64'd2)
    / CLK_PERIOD_NS;
  // half-second ticks in one tenth of a year (365.25 days)
  localparam longint unsigned TENTH_YEAR_HALF = 64'd6311520;
  localparam int DIV_W = 32;

  localparam int RT_SET_W = 10;
  localparam logic [RT_SET_W-1:0] RT_SET_MAX = 10'h3E7;
  localparam logic [RT_SET_W-1:0] RT_SET_DEF = 10'h064;
  localparam int RT_ACC_W = 16;
  localparam int ON_SET_W = 14;
  localparam logic [ON_SET_W-1:0] ON_SET_MAX = 14'h270F;
  localparam logic [ON_SET_W-1:0] ON_SET_DEF = 14'h0064;
  localparam int ON_ACC_W = 32;
  localparam logic [ON_ACC_W-1:0] ON_UNIT = 32'h000003E8;
  localparam int N_OUT = 2;

  localparam int VAL_W = 24;
  localparam logic signed [VAL_W-1:0] UFLOW_LIM = -24'sd99999;
  localparam logic signed [VAL_W-1:0] OFLOW_LIM = 24'sd999999;

  localparam int LEVEL_W = 3;
  localparam logic [LEVEL_W-1:0] LVL_ONE = 3'h1;
  localparam logic [LEVEL_W-1:0] LVL_TWO = 3'h2;
  localparam logic [LEVEL_W-1:0] LVL_THREE = 3'h3;
  localparam logic [LEVEL_W-1:0] LVL_FOUR = 3'h4;
  localparam logic [LEVEL_W-1:0] LVL_FIVE = 3'h5;
  localparam logic [LEVEL_W-1:0] LVL_SIX = 3'h6;
  localparam logic [LEVEL_W-1:0] LVL_SEVEN = 3'h7;
  localparam logic [LEVEL_W-1:0] LVL_DEF = LVL_ONE;

  localparam int PIN_HOLD = 0;
  localparam int PIN_PROT = 1;
  localparam int PIN_RST = 2;
  localparam int PIN_KDISP = 3;
  localparam int PIN_KRST = 4;
  localparam int PIN_KUP = 5;
  localparam int PIN_KDN = 6;
  localparam int PIN_KMODE = 7;
  localparam int PIN_N = 8;

  typedef enum logic [2:0] {
    CSL_DISP_NORMAL,
    CSL_DISP_UFLOW,
    CSL_DISP_OFLOW,
    CSL_DISP_CPU,
    CSL_DISP_RAM,
    CSL_DISP_NVM,
    CSL_DISP_REPLACE
  } csl_disp_e;
endpackage

// >>> src/csl_tick_if.sv
// interface between the supervision core and a tick divider
`timescale 1ns/10ps
interface csl_tick_if (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce
);
  logic step;
  logic tick;
  modport div (input clk, input srst, input ce, input step, output tick);
  modport user (output step, input tick);
endinterface

// >>> src/csl_tick.sv
// divider that emits one tick pulse every LIMIT steps
`timescale 1ns/10ps
module csl_tick #(
  parameter longint unsigned LIMIT = 2
) (
  csl_tick_if.div t
);
  import csl_pkg::*;
  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (t.step)
    begin
      if (cnt_r == DIV_W'(LIMIT - 64'd1))
      begin
        cnt_nxt = '0;
        tick_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge t.clk)
  begin
    if (t.srst)
    begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else if (t.ce)
    begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign t.tick = tick_r;
endmodule

// >>> src/csl_top.sv
// supervision core: hold, key protect, replacement alarms, self-diagnosis
`timescale 1ns/10ps
// Summary of operation
// - hold freezes display value and outputs
// - protection acts only with switch on
// - protect indicator lit while switch on
// - seven levels gate display, reset, up/down
// - setting modes refused while switch on
// - run-time threshold 0.0-99.9 years, zero disables
// - run time reaching threshold raises replacement
// - on-count threshold thousands 0-9999, zero disables
// - any output reaching threshold raises replacement
// - underflow flashes, outputs kept, reset clears
// - overflow flashes, outputs kept, reset clears
// - processor fault: outputs off, sub blank
// - memory fault: outputs off, power cycle only
// - storage fault: off, checksum, reset restores defaults
// - replacement alternates display, outputs unchanged
// - reset never clears run time, on counts
// - reset key suppresses replacement until power-up
// - power-up re-evaluates replacement thresholds
module csl_top #(
  parameter longint unsigned HALF_SEC_CYC = csl_pkg::FLASH_HALF_CYC,
  parameter longint unsigned TENTH_YEAR_HALVES = csl_pkg::TENTH_YEAR_HALF
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [csl_pkg::PIN_N-1:0] pin_in,
  input wire logic set_wr,
  input wire logic [csl_pkg::LEVEL_W-1:0] set_level,
  input wire logic [csl_pkg::RT_SET_W-1:0] set_rt,
  input wire logic [csl_pkg::ON_SET_W-1:0] set_on1,
  input wire logic [csl_pkg::ON_SET_W-1:0] set_on2,
  input wire logic acc_load,
  input wire logic [csl_pkg::RT_ACC_W-1:0] load_rt,
  input wire logic [csl_pkg::ON_ACC_W-1:0] load_on1,
  input wire logic [csl_pkg::ON_ACC_W-1:0] load_on2,
  input wire logic signed [csl_pkg::VAL_W-1:0] meas_value,
  input wire logic signed [csl_pkg::VAL_W-1:0] present_value,
  input wire logic signed [csl_pkg::VAL_W-1:0] total_value,
  input wire logic oflow_qualify,
  input wire logic [csl_pkg::N_OUT-1:0] out_req,
  input wire logic cpu_fault,
  input wire logic ram_fault,
  input wire logic nvm_fault,
  output logic [csl_pkg::N_OUT-1:0] relay_out,
  output logic signed [csl_pkg::VAL_W-1:0] disp_value,
  output csl_pkg::csl_disp_e disp_code,
  output logic disp_lit,
  output logic sub_blank,
  output logic checksum_indication,
  output logic protect_led,
  output logic key_disp_ok,
  output logic key_reset_ok,
  output logic key_up_ok,
  output logic key_down_ok,
  output logic mode_change_ok,
  output logic replacement_due_error,
  output logic [csl_pkg::LEVEL_W-1:0] level_cur,
  output logic [csl_pkg::RT_SET_W-1:0] rt_set_cur,
  output logic [csl_pkg::RT_ACC_W-1:0] rt_acc,
  output logic [csl_pkg::ON_ACC_W-1:0] on_cnt1,
  output logic [csl_pkg::ON_ACC_W-1:0] on_cnt2
);
  import csl_pkg::*;

  // pin synchronisers; only sync2_r and prev_r feed logic
  logic [PIN_N-1:0] sync1_r;
  logic [PIN_N-1:0] sync2_r;
  logic [PIN_N-1:0] prev_r;
  logic [PIN_N-1:0] rise;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end
    else if (clk_en)
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign rise = sync2_r & ~prev_r;

  logic hold;
  logic prot_on;
  assign hold = sync2_r[PIN_HOLD];
  assign prot_on = sync2_r[PIN_PROT];
  assign protect_led = prot_on;

  // time bases: half-second phase and tenth-year run-time step
  csl_tick_if half_if (.clk(core_clk), .srst(srst), .ce(clk_en));
  csl_tick_if year_if (.clk(core_clk), .srst(srst), .ce(clk_en));
  assign half_if.step = 1'b1;
  assign year_if.step = half_if.tick;

  csl_tick #(.LIMIT(HALF_SEC_CYC)) u_half (.t(half_if));
  csl_tick #(.LIMIT(TENTH_YEAR_HALVES)) u_year (.t(year_if));

  // settings, loaded from function setting mode
  logic [LEVEL_W-1:0] level_r;
  logic [LEVEL_W-1:0] level_nxt;
  logic [RT_SET_W-1:0] rt_set_r;
  logic [RT_SET_W-1:0] rt_set_nxt;
  logic [ON_SET_W-1:0] on_set_r [N_OUT];
  logic [ON_SET_W-1:0] on_set_nxt [N_OUT];
  logic factory_restore;

  always_comb
  begin
    level_nxt = level_r;
    rt_set_nxt = rt_set_r;
    on_set_nxt = on_set_r;
    if (factory_restore)
    begin
      level_nxt = LVL_DEF;
      rt_set_nxt = RT_SET_DEF;
      on_set_nxt[0] = ON_SET_DEF;
      on_set_nxt[1] = ON_SET_DEF;
    end
    else if (set_wr)
    begin
      // level zero is not a level; out-of-range values saturate
      level_nxt = (set_level == '0) ? LVL_ONE : set_level;
      rt_set_nxt = (set_rt > RT_SET_MAX) ? RT_SET_MAX : set_rt;
      on_set_nxt[0] = (set_on1 > ON_SET_MAX) ? ON_SET_MAX : set_on1;
      on_set_nxt[1] = (set_on2 > ON_SET_MAX) ? ON_SET_MAX : set_on2;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      level_r <= LVL_DEF;
      rt_set_r <= RT_SET_DEF;
      on_set_r[0] <= ON_SET_DEF;
      on_set_r[1] <= ON_SET_DEF;
    end
    else if (clk_en)
    begin
      level_r <= level_nxt;
      rt_set_r <= rt_set_nxt;
      on_set_r <= on_set_nxt;
    end
  end

  // key gating by protect level
  logic ok_disp;
  logic ok_rst;
  logic ok_updn;

  always_comb
  begin
    ok_disp = 1'b1;
    ok_rst = 1'b1;
    ok_updn = 1'b1;
    if (prot_on)
    begin
      case (level_r)
        LVL_TWO: ok_rst = 1'b0;
        LVL_THREE: ok_updn = 1'b0;
        LVL_FOUR:
        begin
          ok_rst = 1'b0;
          ok_updn = 1'b0;
        end
        LVL_FIVE:
        begin
          ok_disp = 1'b0;
          ok_rst = 1'b0;
          ok_updn = 1'b0;
        end
        LVL_SIX: ok_disp = 1'b0;
        LVL_SEVEN:
        begin
          ok_disp = 1'b0;
          ok_rst = 1'b0;
        end
        default: ;
      endcase
    end
  end

  logic reset_key;
  logic reset_any;
  assign key_disp_ok = rise[PIN_KDISP] & ok_disp;
  assign reset_key = rise[PIN_KRST] & ok_rst;
  assign key_reset_ok = reset_key;
  assign key_up_ok = rise[PIN_KUP] & ok_updn;
  assign key_down_ok = rise[PIN_KDN] & ok_updn;
  assign mode_change_ok = rise[PIN_KMODE] & ~prot_on;
  assign reset_any = reset_key | sync2_r[PIN_RST];

  // run time and on counts; no reset action touches them
  logic [RT_ACC_W-1:0] rt_acc_r;
  logic [RT_ACC_W-1:0] rt_acc_nxt;
  logic [ON_ACC_W-1:0] on_cnt_r [N_OUT];
  logic [ON_ACC_W-1:0] on_cnt_nxt [N_OUT];
  logic [N_OUT-1:0] relay_r;
  logic [N_OUT-1:0] relay_nxt;
  logic [N_OUT-1:0] relay_prev_r;

  always_comb
  begin
    rt_acc_nxt = rt_acc_r;
    on_cnt_nxt = on_cnt_r;
    if (acc_load)
    begin
      rt_acc_nxt = load_rt;
      on_cnt_nxt[0] = load_on1;
      on_cnt_nxt[1] = load_on2;
    end
    else
    begin
      if (year_if.tick && rt_acc_r != '1)
        rt_acc_nxt = rt_acc_r + 1'b1;
      for (int i = 0; i < N_OUT; i++)
      begin
        if (relay_r[i] && !relay_prev_r[i] && on_cnt_r[i] != '1)
          on_cnt_nxt[i] = on_cnt_r[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rt_acc_r <= '0;
      on_cnt_r[0] <= '0;
      on_cnt_r[1] <= '0;
      relay_prev_r <= '0;
    end
    else if (clk_en)
    begin
      rt_acc_r <= rt_acc_nxt;
      on_cnt_r <= on_cnt_nxt;
      relay_prev_r <= relay_r;
    end
  end

  logic rt_hit;
  logic [N_OUT-1:0] on_hit;
  assign rt_hit = (rt_set_r != '0) && (rt_acc_r >= RT_ACC_W'(rt_set_r));
  always_comb
  begin
    for (int i = 0; i < N_OUT; i++)
      on_hit[i] = (on_set_r[i] != '0)
        && (on_cnt_r[i] >= ON_ACC_W'(on_set_r[i]) * ON_UNIT);
  end

  // error flags; a new cause wins over a clear in the same cycle
  logic uflow_r;
  logic uflow_nxt;
  logic oflow_r;
  logic oflow_nxt;
  logic cpu_r;
  logic cpu_nxt;
  logic ram_r;
  logic ram_nxt;
  logic nvm_r;
  logic nvm_nxt;
  logic supp_r;
  logic supp_nxt;
  logic uflow_cause;
  logic oflow_cause;

  assign uflow_cause = (present_value < UFLOW_LIM) || (total_value < UFLOW_LIM);
  assign oflow_cause = oflow_qualify && (present_value > OFLOW_LIM);
  assign factory_restore = nvm_r & reset_key & ~nvm_fault;

  always_comb
  begin
    uflow_nxt = uflow_cause | (uflow_r & ~reset_any);
    oflow_nxt = oflow_cause | (oflow_r & ~reset_any);
    cpu_nxt = cpu_fault | (cpu_r & ~reset_key);
    ram_nxt = ram_fault | ram_r;
    nvm_nxt = nvm_fault | (nvm_r & ~reset_key);
    // suppression lasts until srst, which models the power cycle
    supp_nxt = supp_r | reset_key;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      uflow_r <= 1'b0;
      oflow_r <= 1'b0;
      cpu_r <= 1'b0;
      ram_r <= 1'b0;
      nvm_r <= 1'b0;
      supp_r <= 1'b0;
    end
    else if (clk_en)
    begin
      uflow_r <= uflow_nxt;
      oflow_r <= oflow_nxt;
      cpu_r <= cpu_nxt;
      ram_r <= ram_nxt;
      nvm_r <= nvm_nxt;
      supp_r <= supp_nxt;
    end
  end

  logic replace;
  logic fault;
  assign replace = (rt_hit | (|on_hit)) & ~supp_r;
  assign fault = cpu_r | ram_r | nvm_r;
  assign replacement_due_error = replace;

  // outputs and display
  logic phase_r;
  logic phase_nxt;
  logic signed [VAL_W-1:0] dval_r;
  logic signed [VAL_W-1:0] dval_nxt;
  csl_disp_e code_r;
  csl_disp_e code_nxt;
  logic lit_r;
  logic lit_nxt;
  logic blank_r;
  logic blank_nxt;
  logic sum_r;
  logic sum_nxt;

  always_comb
  begin
    phase_nxt = phase_r ^ half_if.tick;
    dval_nxt = hold ? dval_r : meas_value;
    // faults override hold; flash errors and hold keep the relays
    if (fault)
      relay_nxt = '0;
    else if (hold || uflow_r || oflow_r)
      relay_nxt = relay_r;
    else
      relay_nxt = out_req;
    code_nxt = CSL_DISP_NORMAL;
    lit_nxt = 1'b1;
    blank_nxt = 1'b0;
    sum_nxt = 1'b0;
    if (cpu_r)
    begin
      code_nxt = CSL_DISP_CPU;
      blank_nxt = 1'b1;
    end
    else if (ram_r)
    begin
      code_nxt = CSL_DISP_RAM;
      blank_nxt = 1'b1;
    end
    else if (nvm_r)
    begin
      code_nxt = CSL_DISP_NVM;
      sum_nxt = 1'b1;
    end
    else if (uflow_r)
    begin
      code_nxt = CSL_DISP_UFLOW;
      lit_nxt = phase_r;
    end
    else if (oflow_r)
    begin
      code_nxt = CSL_DISP_OFLOW;
      lit_nxt = phase_r;
    end
    else if (replace && phase_r)
      code_nxt = CSL_DISP_REPLACE;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      phase_r <= 1'b0;
      dval_r <= '0;
      relay_r <= '0;
      code_r <= CSL_DISP_NORMAL;
      lit_r <= 1'b1;
      blank_r <= 1'b0;
      sum_r <= 1'b0;
    end
    else if (clk_en)
    begin
      phase_r <= phase_nxt;
      dval_r <= dval_nxt;
      relay_r <= relay_nxt;
      code_r <= code_nxt;
      lit_r <= lit_nxt;
      blank_r <= blank_nxt;
      sum_r <= sum_nxt;
    end
  end

  assign relay_out = relay_r;
  assign disp_value = dval_r;
  assign disp_code = code_r;
  assign disp_lit = lit_r;
  assign sub_blank = blank_r;
  assign checksum_indication = sum_r;
  assign level_cur = level_r;
  assign rt_set_cur = rt_set_r;
  assign rt_acc = rt_acc_r;
  assign on_cnt1 = on_cnt_r[0];
  assign on_cnt2 = on_cnt_r[1];
endmodule

// >>> sim/csl_chk_assertions.sv
// port-level concurrent checks for the supervision core
`timescale 1ns/10ps
module csl_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic acc_load,
  input wire logic [csl_pkg::PIN_N-1:0] pin_in,
  input wire logic signed [csl_pkg::VAL_W-1:0] present_value,
  input wire logic cpu_fault,
  input wire logic ram_fault,
  input wire logic nvm_fault,
  input wire logic [csl_pkg::N_OUT-1:0] relay_out,
  input wire logic signed [csl_pkg::VAL_W-1:0] disp_value,
  input wire csl_pkg::csl_disp_e disp_code,
  input wire logic sub_blank,
  input wire logic checksum_indication,
  input wire logic protect_led,
  input wire logic key_disp_ok,
  input wire logic key_reset_ok,
  input wire logic key_up_ok,
  input wire logic key_down_ok,
  input wire logic mode_change_ok,
  input wire logic [csl_pkg::LEVEL_W-1:0] level_cur,
  input wire logic [csl_pkg::RT_ACC_W-1:0] rt_acc,
  input wire logic [csl_pkg::ON_ACC_W-1:0] on_cnt1
);
  import csl_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  property p_led;
    $rose(pin_in[PIN_PROT]) ##1 pin_in[PIN_PROT] |-> ##1 protect_led;
  endproperty
  a_led: assert property (p_led) else $error("protect lamp late");
  property p_krst;
    key_reset_ok |-> !(protect_led && level_cur inside {3'h2, 3'h4, 3'h5, 3'h7});
  endproperty
  a_krst: assert property (p_krst) else $error("reset key passed");
  property p_kud;
    key_up_ok || key_down_ok |-> !(protect_led && level_cur inside {3'h3, 3'h4, 3'h5});
  endproperty
  a_kud: assert property (p_kud) else $error("up down key passed");
  property p_kdisp;
    key_disp_ok |-> !(protect_led && level_cur inside {3'h5, 3'h6, 3'h7});
  endproperty
  a_kdisp: assert property (p_kdisp) else $error("display key passed");
  property p_mode;
    mode_change_ok |-> !protect_led;
  endproperty
  a_mode: assert property (p_mode) else $error("mode change passed");
  property p_hold;
    (pin_in[PIN_HOLD] && !(cpu_fault || ram_fault || nvm_fault))[*4]
      |=> $stable(relay_out) && $stable(disp_value);
  endproperty
  a_hold: assert property (p_hold) else $error("hold not frozen");
  property p_uflow;
    present_value < UFLOW_LIM |-> ##2
      disp_code inside {CSL_DISP_UFLOW, CSL_DISP_CPU, CSL_DISP_RAM, CSL_DISP_NVM};
  endproperty
  a_uflow: assert property (p_uflow) else $error("underflow not shown");
  property p_cpu;
    cpu_fault |-> ##2 relay_out == '0 && sub_blank && disp_code == CSL_DISP_CPU;
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu fault handling");
  property p_ram;
    ram_fault |-> ##2 relay_out == '0 && sub_blank;
  endproperty
  a_ram: assert property (p_ram) else $error("ram fault handling");
  property p_nvm;
    nvm_fault |-> ##2 relay_out == '0 && checksum_indication;
  endproperty
  a_nvm: assert property (p_nvm) else $error("storage fault handling");
  property p_keep;
    !acc_load |=> rt_acc >= $past(rt_acc) && on_cnt1 >= $past(on_cnt1);
  endproperty
  a_keep: assert property (p_keep) else $error("accumulator went back");
endmodule
bind csl_top csl_chk chk_u (.*);

// >>> sim/csl_panel.sv
// partner model: panel keys and switches, relay contact counter
`timescale 1ns/10ps
module csl_panel (
  input wire logic core_clk,
  input wire logic [csl_pkg::PIN_N-1:0] lvl,
  input wire logic [csl_pkg::PIN_N-1:0] tap,
  input wire logic [csl_pkg::N_OUT-1:0] relay_out,
  output logic [csl_pkg::PIN_N-1:0] pin_in,
  output int closes
);
  import csl_pkg::*;
  logic [PIN_N-1:0] held = '0;
  logic prev = 1'h0;
  int age = 0;
  assign pin_in = lvl | held;
  // a tap holds the key four cycles: long enough to sync, short of a double press
  always @(posedge core_clk)
  begin
    prev <= relay_out[0];
    closes <= closes + int'(relay_out[0] & ~prev);
    age <= (tap != '0) ? 4 : (age > 0 ? age - 1 : 0);
    held <= (tap != '0) ? tap : (age > 1 ? held : '0);
  end
endmodule

// >>> sim/testbench.sv
// self-checking bench for the supervision core
`timescale 1ns/10ps
module testbench;
  import csl_pkg::*;
  logic core_clk = 1'h0, srst = 1'h1, clk_en = 1'h1, oflow_qualify = 1'h0;
  logic set_wr = 1'h0, acc_load = 1'h0, cpu_fault = 1'h0, ram_fault = 1'h0, nvm_fault = 1'h0;
  logic [LEVEL_W-1:0] set_level = 3'h1;
  logic [RT_SET_W-1:0] set_rt = 10'h000;
  logic [ON_SET_W-1:0] set_on1 = 14'h0000, set_on2 = 14'h0000;
  logic [RT_ACC_W-1:0] load_rt = 16'h0000;
  logic [ON_ACC_W-1:0] load_on1 = 32'h0, load_on2 = 32'h0;
  logic signed [VAL_W-1:0] meas_value = 24'sh0, present_value = 24'sh0, total_value = 24'sh0;
  logic [N_OUT-1:0] out_req = 2'h0, relay_out;
  logic [PIN_N-1:0] lvl = 8'h00, tap = 8'h00, pin_in;
  logic signed [VAL_W-1:0] disp_value;
  csl_disp_e disp_code;
  logic disp_lit, sub_blank, checksum_indication, protect_led, key_disp_ok, key_reset_ok;
  logic key_up_ok, key_down_ok, mode_change_ok, replacement_due_error;
  logic [LEVEL_W-1:0] level_cur;
  logic [RT_SET_W-1:0] rt_set_cur;
  logic [RT_ACC_W-1:0] rt_acc;
  logic [ON_ACC_W-1:0] on_cnt1, on_cnt2;
  int closes, kc[4], bad_count = 0, samples_checked = 0;
  csl_top #(.HALF_SEC_CYC(4), .TENTH_YEAR_HALVES(3)) dut_u (.*);
  csl_panel panel_u (.*);
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    kc[0] += int'(key_disp_ok);
    kc[1] += int'(key_reset_ok);
    kc[2] += int'(key_up_ok) + int'(key_down_ok);
    kc[3] += int'(mode_change_ok);
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(logic [2:0] lv, logic [9:0] rt, logic [13:0] o1);
    @(posedge core_clk);
    set_level <= lv;
    set_rt <= rt;
    set_on1 <= o1;
    set_wr <= 1'h1;
    @(posedge core_clk);
    set_wr <= 1'h0;
    cyc(1);
  endtask
  task automatic press(logic [7:0] m);
    @(posedge core_clk);
    tap <= m;
    @(posedge core_clk);
    tap <= 8'h00;
    cyc(6);
  endtask
  task automatic pulse_acc(logic [15:0] rt, logic [31:0] o1);
    load_rt <= rt;
    load_on1 <= o1;
    acc_load <= 1'h1;
    cyc(1);
    acc_load <= 1'h0;
    cyc(2);
  endtask
  // power cycle: srst over two edges, then one idle edge
  task automatic pcyc();
    srst <= 1'h1;
    cyc(2);
    srst <= 1'h0;
    cyc(1);
  endtask
  task automatic t_protect();
    for (int i = 1; i <= 7; i++)
    begin
      wr(3'(i), 10'h000, 14'h0000);
      lvl[PIN_PROT] <= 1'h1;
      cyc(4);
      kc = '{default: 0};
      press(8'hF8);
      chk("led", protect_led, 32'h1);
      chk("kdisp", kc[0], 32'(i < 5));
      chk("kreset", kc[1], 32'(i inside {1, 3, 6}));
      chk("kupdn", kc[2], 32'(2 * (i < 3 || i > 5)));
      chk("kmode", kc[3], 32'h0);
    end
    lvl[PIN_PROT] <= 1'h0;
    cyc(4);
    kc = '{default: 0};
    press(8'hF8);
    chk("led", protect_led, 32'h0);
    chk("kall", kc[0] + kc[1] + kc[2] + kc[3], 32'h5);
  endtask
  task automatic t_hold();
    out_req <= 2'h1;
    meas_value <= 24'sh000005;
    cyc(4);
    lvl[PIN_HOLD] <= 1'h1;
    cyc(4);
    out_req <= 2'h2;
    meas_value <= 24'sh000007;
    cyc(4);
    chk("relay", relay_out, 32'h1);
    chk("disp", disp_value, 32'h5);
    lvl[PIN_HOLD] <= 1'h0;
    cyc(5);
    chk("relay", relay_out, 32'h2);
    chk("disp", disp_value, 32'h7);
    out_req <= 2'h0;
  endtask
  task automatic t_runtime();
    logic seen;
    // reset-key presses above left the indication suppressed until power-up
    pcyc();
    wr(3'h1, 10'h002, 14'h0000);
    for (int i = 0; i < 300 && rt_acc < 16'h0002; i++) @(posedge core_clk);
    cyc(1);
    chk("rpl", replacement_due_error, 32'h1);
    seen = 1'h0;
    repeat (12) @(posedge core_clk) seen |= (disp_code === CSL_DISP_REPLACE);
    chk("alt", seen, 32'h1);
    chk("relay", relay_out, 32'h0);
    wr(3'h1, 10'h000, 14'h0000);
    chk("rpl", replacement_due_error, 32'h0);
    wr(3'h1, 10'h002, 14'h0000);
    press(8'h10);
    chk("rpl", replacement_due_error, 32'h0);
    chk("rtkeep", 32'(rt_acc >= 16'h0002), 32'h1);
    pcyc();
    pulse_acc(16'h00C8, 32'h0);
    chk("rtdef", rt_set_cur, 32'h64);
    chk("rpl", replacement_due_error, 32'h1);
  endtask
  task automatic t_oncount();
    int n;
    wr(3'h1, 10'h000, 14'h0001);
    pulse_acc(16'h0000, 32'h000003E7);
    n = closes;
    chk("rpl", replacement_due_error, 32'h0);
    out_req <= 2'h1;
    cyc(4);
    chk("oncnt", on_cnt1, 32'h3E8);
    chk("closes", closes - n, 32'h1);
    chk("rpl", replacement_due_error, 32'h1);
    wr(3'h1, 10'h000, 14'h0000);
    chk("rpl", replacement_due_error, 32'h0);
    set_on2 <= 14'h0001;
    load_on2 <= 32'h000003E7;
    wr(3'h1, 10'h000, 14'h0000);
    pulse_acc(16'h0000, 32'h000003E8);
    out_req <= 2'h2;
    cyc(4);
    chk("oncnt2", on_cnt2, 32'h3E8);
    chk("rpl2", replacement_due_error, 32'h1);
    press(8'h10);
    chk("oncnt", on_cnt1, 32'h3E8);
    chk("oncnt2", on_cnt2, 32'h3E8);
    chk("rpl", replacement_due_error, 32'h0);
  endtask
  task automatic t_faults();
    logic [1:0] seen;
    // move the request only once the underflow is latched
    present_value <= -24'sd100000;
    cyc(2);
    out_req <= 2'h0;
    cyc(2);
    chk("uflow", disp_code, CSL_DISP_UFLOW);
    chk("relay", relay_out, 32'h2);
    seen = 2'h0;
    repeat (12) @(posedge core_clk) seen |= {disp_lit, ~disp_lit};
    chk("flash", seen, 32'h3);
    cpu_fault <= 1'h1;
    cyc(1);
    cpu_fault <= 1'h0;
    cyc(3);
    chk("cpu", disp_code, CSL_DISP_CPU);
    chk("relay", relay_out, 32'h0);
    present_value <= 24'sh0;
    press(8'h10);
    chk("clear", disp_code, CSL_DISP_NORMAL);
    oflow_qualify <= 1'h1;
    present_value <= 24'sd1000000;
    cyc(4);
    chk("oflow", disp_code, CSL_DISP_OFLOW);
    present_value <= 24'sh0;
    lvl[PIN_RST] <= 1'h1;
    cyc(4);
    lvl[PIN_RST] <= 1'h0;
    oflow_qualify <= 1'h0;
    cyc(2);
    chk("oclr", disp_code, CSL_DISP_NORMAL);
    wr(3'h3, 10'h000, 14'h0000);
    nvm_fault <= 1'h1;
    cyc(1);
    nvm_fault <= 1'h0;
    cyc(3);
    chk("sum", checksum_indication, 32'h1);
    press(8'h10);
    chk("factory", level_cur, 32'h1);
    ram_fault <= 1'h1;
    cyc(1);
    ram_fault <= 1'h0;
    press(8'h10);
    chk("ram", disp_code, CSL_DISP_RAM);
    pcyc();
    cyc(2);
    chk("ramclr", disp_code, CSL_DISP_NORMAL);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    srst <= 1'h0;
    cyc(1);
    chk("level", level_cur, 32'h1);
    chk("rtdef", rt_set_cur, 32'h64);
    wr(3'h1, 10'h000, 14'h0000);
    t_protect();
    t_hold();
    t_runtime();
    t_oncount();
    t_faults();
    tally_and_finish();
  end
  // far above the few hundred cycles the sequence needs
  initial
  begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule
